// File: design/mhf_framer.sv
// monitoring header framer: buffers a filtered frame, prefixes a 32-byte
// header, streams it through an output fifo; also time base, counters, events
// assumes upstream logic on sys_clk_i; link and ntp status pins are async
`timescale 1ns/1ps
`include "mhf_regs.svh"

// fifo with valid/ready on both sides
module mhf_fifo #(
  parameter int W     = 65,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  // fill side
  input  wire logic         wr_valid_i,
  output logic              wr_ready_o,
  input  wire logic [W-1:0] wr_data_i,
  // drain side
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [W-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wptr_r, wptr_nxt;
  logic [AW:0]  rptr_r, rptr_nxt;
  logic         push, pop;

  // pointer arithmetic, one spare bit tells full from empty
  always_comb begin
    push     = wr_valid_i && wr_ready_o;
    pop      = rd_valid_o && rd_ready_i;
    wptr_nxt = wptr_r + (AW+1)'(push);
    rptr_nxt = rptr_r + (AW+1)'(pop);
  end
  assign wr_ready_o = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
  assign rd_valid_o = wptr_r != rptr_r;
  assign rd_data_o  = mem_r[rptr_r[AW-1:0]];

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
    end
  end

  // storage, no reset needed
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_r[wptr_r[AW-1:0]] <= wr_data_i;
  end
endmodule : mhf_fifo

module mhf_framer #(
  parameter int          MAX_BEATS  = 256,
  parameter int          FIFO_DEPTH = 8,
  parameter logic [39:0] OBS_CYCLES = 40'(64'(`MHF_OBS_MIN) * 64'd60 *
                                      64'(`MHF_CLK_MHZ) * 64'd1000000)
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // filtered frame input
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  input  wire mhf_pkg::mhf_beat_t in_beat_i,
  input  wire mhf_pkg::mhf_meta_t in_meta_i,
  // monitoring stream output
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [63:0]            out_data_o,
  output logic                   out_last_o,
  // configuration
  input  wire logic [31:0]       fill_timeout_i,
  // time base
  input  wire logic              time_set_i,
  input  wire logic [63:0]       time_set_val_i,
  input  wire logic              ntp_off_valid_i,
  input  wire logic signed [31:0] ntp_off_i,
  input  wire logic              ntp_sync_i,
  output logic [63:0]            time_o,
  // statistics pulses and counters
  input  wire logic              rx_frame_i,
  input  wire logic              crc_err_i,
  input  wire logic              match_i,
  input  wire logic              proc_drop_i,
  input  wire logic              queue_drop_i,
  output mhf_pkg::mhf_cnt_t      cnt_o,
  // events
  input  wire logic              link1g_i,
  input  wire logic              link10g_i,
  output logic                   ev_loss_o,
  output logic                   ev_ntp_sync_o,
  output logic                   ev_link1g_o,
  output logic                   ev_link10g_o,
  output logic                   traffic_seen_o,
  output logic                   obs_done_o
);
  localparam int BW = $clog2(MAX_BEATS) + 1;
  localparam logic [31:0] NOM = 32'((64'h1_0000_0000 * 64'(`MHF_CLK_NS)) /
                                    64'(`MHF_TS_UNIT_NS));
  localparam logic signed [31:0] LIM = signed'(NOM >> 1);

  function automatic logic [31:0] bsum(input logic [63:0] w);
    logic [31:0] s;
    s = 32'h0;
    for (int k = 0; k < 8; k++) s = s + 32'(w[8*k +: 8]);
    return s;
  endfunction

  // time base: 100 ns ticks plus a 32-bit fraction, rate-steered
  logic [63:0]        time_r, time_nxt;
  logic [31:0]        frac_r, frac_nxt;
  logic signed [31:0] corr_r, corr_nxt;
  logic               tset_r, tset_nxt;
  logic [32:0]        fsum;
  always_comb begin
    fsum     = {1'b0, frac_r} + {1'b0, NOM + corr_r};
    frac_nxt = fsum[31:0];
    time_nxt = time_r + 64'(fsum[32]);
    tset_nxt = tset_r;
    corr_nxt = corr_r;
    if (time_set_i && !tset_r) begin
      time_nxt = time_set_val_i;                                      // initial set only
      tset_nxt = 1'b1;
    end
    if (ntp_off_valid_i) begin
      corr_nxt = ntp_off_i <<< `MHF_TS_GAIN;
      if (corr_nxt > LIM) corr_nxt = LIM;
      if (corr_nxt < -LIM) corr_nxt = -LIM;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      time_r <= 64'h0;
      frac_r <= 32'h0;
      corr_r <= 32'sh0;
      tset_r <= 1'b0;
    end else begin
      time_r <= time_nxt;
      frac_r <= frac_nxt;
      corr_r <= corr_nxt;
      tset_r <= tset_nxt;
    end
  end
  assign time_o = time_r;

  // frame engine state
  mhf_pkg::mhf_state_t state_r, state_nxt;
  mhf_pkg::mhf_meta_t  meta_r, meta_nxt;
  logic [63:0]  ts_r, ts_nxt;
  logic [15:0]  clen_r, clen_nxt, clen_c, trnd, cur_clen;
  logic [15:0]  fbytes_r, fbytes_nxt;
  logic [BW-1:0] beats_r, beats_nxt, beats_c, cur_beats;
  logic [BW-1:0] wcnt_r, wcnt_nxt, rcnt_r, rcnt_nxt;
  logic [1:0]   hcnt_r, hcnt_nxt;
  logic [31:0]  dsum_r, dsum_nxt, seq_r, seq_nxt, idle_r, idle_nxt, csum;
  logic         fill_r, fill_nxt, first_r, first_nxt, ready_r, ready_nxt;
  logic         take, buf_we, wr_valid, wr_ready, wr_last;
  logic [63:0]  in_mask, wr_data, w0, w1, w3z;
  logic [63:0]  buf_r [MAX_BEATS];

  // carried length from the first beat's facts
  always_comb begin
    trnd = {in_meta_i.trunc_len[15:3] + 13'(|in_meta_i.trunc_len[2:0]), 3'b000};
    clen_c = (in_meta_i.trunc_en && in_meta_i.orig_len > trnd) ?
             trnd : in_meta_i.orig_len;
    if (clen_c > 16'(MAX_BEATS * 8)) clen_c = 16'(MAX_BEATS * 8);
    beats_c   = BW'(({1'b0, clen_c} + 17'h7) >> 3);
    cur_clen  = first_r ? clen_c : clen_r;
    cur_beats = first_r ? beats_c : beats_r;
    take      = in_valid_i && ready_r;
  end

  // bytes past the carried length become zero padding
  for (genvar k = 0; k < 8; k++) begin : g_mask
    assign in_mask[8*k +: 8] = (16'({wcnt_r, 3'(k)}) < cur_clen) ?
                               in_beat_i.data[8*k +: 8] : 8'h00;
  end

  // header words, little-endian on the 64-bit bus
  always_comb begin
    w0 = {meta_r.source_interface_id, `MHF_RSVD_VAL,
          fill_r ? `MHF_TYPE_FILL : `MHF_TYPE_DATA, `MHF_SYNC_WORD};
    w1 = {meta_r.source_interface_id, meta_r.output_link_tag, seq_r};
    w3z = {meta_r.orig_len, clen_r, 32'h0};
    csum = dsum_r + bsum(w0) + bsum(w1) + bsum(ts_r) + bsum(w3z);
    case (hcnt_r)
      2'h0:    wr_data = w0;
      2'h1:    wr_data = w1;
      2'h2:    wr_data = ts_r;
      default: wr_data = w3z | {32'h0, csum};
    endcase
    if (state_r == mhf_pkg::S_DAT) wr_data = buf_r[rcnt_r[BW-2:0]];
    wr_valid = state_r != mhf_pkg::S_RX;
    wr_last  = (state_r == mhf_pkg::S_DAT) ? (rcnt_r == beats_r - BW'(1)) :
               (hcnt_r == `MHF_HDR_LAST && (fill_r || beats_r == '0));
  end

  // capture, header and data sequencing
  always_comb begin
    state_nxt = state_r;   meta_nxt  = meta_r;  ts_nxt   = ts_r;
    clen_nxt  = clen_r;    beats_nxt = beats_r; wcnt_nxt = wcnt_r;
    rcnt_nxt  = rcnt_r;    hcnt_nxt  = hcnt_r;  dsum_nxt = dsum_r;
    seq_nxt   = seq_r;     fill_nxt  = fill_r;  first_nxt = first_r;
    idle_nxt  = idle_r;    fbytes_nxt = fbytes_r;
    ready_nxt = ready_r;   buf_we    = 1'b0;
    case (state_r)
      mhf_pkg::S_RX: begin
        if (take) begin
          idle_nxt  = 32'h0;
          first_nxt = in_beat_i.last;
          if (first_r) begin
            meta_nxt  = in_meta_i;
            ts_nxt    = time_r;
            clen_nxt  = clen_c;
            beats_nxt = beats_c;
          end
          if (wcnt_r < cur_beats) begin
            buf_we   = 1'b1;
            wcnt_nxt = wcnt_r + BW'(1);
            dsum_nxt = dsum_r + bsum(in_mask);
          end
          if (in_beat_i.last) begin
            state_nxt  = mhf_pkg::S_HDR;
            hcnt_nxt   = 2'h0;
            fill_nxt   = 1'b0;
            ready_nxt  = 1'b0;
            wcnt_nxt   = '0;
            fbytes_nxt = `MHF_HDR_BYTES + cur_clen;
          end
        end else if (first_r && !in_valid_i && idle_r >= fill_timeout_i &&
                     fbytes_r < `MHF_FILL_BYTES) begin
          state_nxt  = mhf_pkg::S_HDR;
          hcnt_nxt   = 2'h0;
          fill_nxt   = 1'b1;
          ready_nxt  = 1'b0;
          meta_nxt   = '0;
          ts_nxt     = time_r;
          clen_nxt   = 16'h0;
          beats_nxt  = '0;
          fbytes_nxt = fbytes_r + `MHF_HDR_BYTES;
        end else if (first_r && idle_r != 32'hFFFFFFFF) begin
          idle_nxt = idle_r + 32'h1;
        end
      end
      mhf_pkg::S_HDR: begin
        if (wr_ready) begin
          hcnt_nxt = hcnt_r + 2'h1;
          if (hcnt_r == `MHF_HDR_LAST) begin
            if (!fill_r) seq_nxt = seq_r + 32'h1;
            if (wr_last) begin
              state_nxt = mhf_pkg::S_RX;
              ready_nxt = 1'b1;
              dsum_nxt  = 32'h0;
            end else begin
              state_nxt = mhf_pkg::S_DAT;
              rcnt_nxt  = '0;
            end
          end
        end
      end
      mhf_pkg::S_DAT: begin
        if (wr_ready) begin
          rcnt_nxt = rcnt_r + BW'(1);
          if (wr_last) begin
            state_nxt = mhf_pkg::S_RX;
            ready_nxt = 1'b1;
            dsum_nxt  = 32'h0;
          end
        end
      end
      default: state_nxt = mhf_pkg::S_RX;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= mhf_pkg::S_RX;  meta_r  <= '0;    ts_r    <= 64'h0;
      clen_r  <= 16'h0;  beats_r <= '0;    wcnt_r  <= '0;
      rcnt_r  <= '0;     hcnt_r  <= 2'h0;  dsum_r  <= 32'h0;
      seq_r   <= 32'h0;  fill_r  <= 1'b0;  first_r <= 1'b1;
      idle_r  <= 32'h0;  fbytes_r <= 16'h0; ready_r <= 1'b1;
    end else begin
      state_r <= state_nxt;  meta_r  <= meta_nxt;  ts_r    <= ts_nxt;
      clen_r  <= clen_nxt;   beats_r <= beats_nxt; wcnt_r  <= wcnt_nxt;
      rcnt_r  <= rcnt_nxt;   hcnt_r  <= hcnt_nxt;  dsum_r  <= dsum_nxt;
      seq_r   <= seq_nxt;    fill_r  <= fill_nxt;  first_r <= first_nxt;
      idle_r  <= idle_nxt;   fbytes_r <= fbytes_nxt; ready_r <= ready_nxt;
    end
  end
  assign in_ready_o = ready_r;

  // frame store
  always_ff @(posedge sys_clk_i) begin
    if (buf_we) buf_r[wcnt_r[BW-2:0]] <= in_mask;
  end

  // output fifo and registered output stage
  logic        rd_valid, rd_ready;
  logic [64:0] rd_data;
  logic        ov_r, ov_nxt, ol_r, ol_nxt;
  logic [63:0] od_r, od_nxt;
  mhf_fifo #(.W(65), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .wr_valid_i(wr_valid),
    .wr_ready_o(wr_ready),
    .wr_data_i ({wr_last, wr_data}),
    .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready),
    .rd_data_o (rd_data)
  );
  always_comb begin
    rd_ready = !ov_r || out_ready_i;
    ov_nxt = ov_r;  od_nxt = od_r;  ol_nxt = ol_r;
    if (rd_ready) begin
      ov_nxt = rd_valid;
      od_nxt = rd_data[63:0];
      ol_nxt = rd_data[64];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ov_r <= 1'b0;
      od_r <= 64'h0;
      ol_r <= 1'b0;
    end else begin
      ov_r <= ov_nxt;
      od_r <= od_nxt;
      ol_r <= ol_nxt;
    end
  end
  assign out_valid_o = ov_r;
  assign out_data_o  = od_r;
  assign out_last_o  = ol_r;

  // statistics counters and events
  mhf_pkg::mhf_cnt_t cnt_r, cnt_nxt;
  logic [2:0]  l1_r, l1_nxt, l10_r, l10_nxt;
  logic [1:0]  ns_r, ns_nxt;
  logic [39:0] obs_r, obs_nxt;
  logic        seen_r, seen_nxt, loss_r, loss_nxt, nso_r, nso_nxt;
  logic        e1_r, e1_nxt, e10_r, e10_nxt, ts_o_r, ts_o_nxt, od_o_r, od_o_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    cnt_nxt.rx_frames   = cnt_r.rx_frames + 32'(rx_frame_i);
    cnt_nxt.crc_errs    = cnt_r.crc_errs + 32'(crc_err_i);
    cnt_nxt.matched     = cnt_r.matched + 32'(match_i);
    cnt_nxt.proc_drops  = cnt_r.proc_drops + 32'(proc_drop_i);
    cnt_nxt.queue_drops = cnt_r.queue_drops + 32'(queue_drop_i);
    l1_nxt   = {l1_r[1:0], link1g_i};
    l10_nxt  = {l10_r[1:0], link10g_i};
    ns_nxt   = {ns_r[0], ntp_sync_i};
    loss_nxt = proc_drop_i || queue_drop_i;
    nso_nxt  = ns_r[1];
    e1_nxt   = l1_r[1] ^ l1_r[2];
    e10_nxt  = l10_r[1] ^ l10_r[2];
    obs_nxt  = obs_r + 40'h1;
    seen_nxt = seen_r || rx_frame_i;
    ts_o_nxt = ts_o_r;
    od_o_nxt = 1'b0;
    if (obs_r >= OBS_CYCLES - 40'h1) begin
      obs_nxt  = 40'h0;
      ts_o_nxt = seen_r || rx_frame_i;
      od_o_nxt = 1'b1;
      seen_nxt = rx_frame_i;                                          // set wins
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;     l1_r <= 3'h0;    l10_r <= 3'h0;  ns_r <= 2'h0;
      obs_r <= 40'h0;  seen_r <= 1'b0;  loss_r <= 1'b0; nso_r <= 1'b0;
      e1_r <= 1'b0;    e10_r <= 1'b0;   ts_o_r <= 1'b0; od_o_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;  l1_r <= l1_nxt;      l10_r <= l10_nxt;  ns_r <= ns_nxt;
      obs_r <= obs_nxt;  seen_r <= seen_nxt;  loss_r <= loss_nxt; nso_r <= nso_nxt;
      e1_r <= e1_nxt;    e10_r <= e10_nxt;    ts_o_r <= ts_o_nxt; od_o_r <= od_o_nxt;
    end
  end
  assign cnt_o          = cnt_r;
  assign ev_loss_o      = loss_r;
  assign ev_ntp_sync_o  = nso_r;
  assign ev_link1g_o    = e1_r;
  assign ev_link10g_o   = e10_r;
  assign traffic_seen_o = ts_o_r;
  assign obs_done_o     = od_o_r;

  // checks
  a_sync_word_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && hcnt_r == 2'h0 && wr_ready)
      |-> wr_data[31:0] == `MHF_SYNC_WORD)
    else $error("sync word wrong");
  a_type_rsvd: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && hcnt_r == 2'h0)
      |-> wr_data[39:32] == (fill_r ? 8'h00 : 8'h01) && wr_data[55:40] == 16'h0)
    else $error("type or reserved field wrong");
  a_source_twice: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && hcnt_r == 2'h1 && wr_ready)
      |-> wr_data[63:56] == $past(wr_data[63:56]))
    else $error("source ids differ");
  a_seq_step: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && hcnt_r == 2'h3 && wr_ready)
      |=> seq_r == $past(seq_r) + ($past(fill_r) ? 32'h0 : 32'h1))
    else $error("sequence step wrong");
  a_no_gap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && hcnt_r == 2'h3 && wr_ready && !wr_last)
      |=> state_r == mhf_pkg::S_DAT && rcnt_r == '0)
    else $error("data does not follow header");
  a_trunc_round: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_HDR && meta_r.orig_len > clen_r && !fill_r)
      |-> clen_r[2:0] == 3'h0)
    else $error("truncation not on 8-byte boundary");
  a_fill_quiet: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_r == mhf_pkg::S_RX && state_nxt == mhf_pkg::S_HDR && fill_nxt)
      |-> !in_valid_i && fbytes_r < `MHF_FILL_BYTES)
    else $error("fill-in over traffic");
  a_time_smooth: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ##1 (!$past(time_set_i) || $past(tset_r))
      |-> time_r - $past(time_r) <= 64'h1)
    else $error("time stepped");
  a_rx_count: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    rx_frame_i |=> cnt_r.rx_frames == $past(cnt_r.rx_frames) + 32'h1)
    else $error("receive counter missed");
endmodule : mhf_framer

// File: design/mhf_pkg.sv
// types shared by the monitoring header framer
// assumes nothing beyond a SystemVerilog compiler
package mhf_pkg;
  // per-frame facts presented with the first beat
  typedef struct packed {
    logic [7:0]  source_interface_id;
    logic [23:0] output_link_tag;
    logic [15:0] orig_len;
    logic [15:0] trunc_len;
    logic        trunc_en;
  } mhf_meta_t;
  // one 64-bit bus beat, bytes little-endian
  typedef struct packed {
    logic        last;
    logic [63:0] data;
  } mhf_beat_t;
  // statistics counters
  typedef struct packed {
    logic [31:0] rx_frames;
    logic [31:0] crc_errs;
    logic [31:0] matched;
    logic [31:0] proc_drops;
    logic [31:0] queue_drops;
  } mhf_cnt_t;
  typedef enum logic [1:0] {
    S_RX  = 2'b00,
    S_HDR = 2'b01,
    S_DAT = 2'b10
  } mhf_state_t;
endpackage : mhf_pkg

// File: design/mhf_regs.svh
// constants of the monitoring header framer: field values, sizes, timing
// assumes inclusion by bare name from the framer design file
`ifndef MHF_REGS_SVH
`define MHF_REGS_SVH
`define MHF_SYNC_WORD  32'h07172738
`define MHF_TYPE_FILL  8'h00
`define MHF_TYPE_DATA  8'h01
`define MHF_RSVD_VAL   16'h0000
`define MHF_HDR_LAST   2'h3
`define MHF_HDR_BYTES  16'h0020
`define MHF_FILL_BYTES 16'h0400
`define MHF_CLK_MHZ    200
`define MHF_CLK_NS     5
`define MHF_TS_UNIT_NS 100
`define MHF_OBS_MIN    5
`define MHF_TS_GAIN    8
`endif

// File: tb/mhf_framer_tb.sv
// bench for the monitoring header framer: frames, stall, counters, events, fill-in
// assumes the framer and the sink model are compiled before it
`timescale 1ns/1ps
module mhf_framer_tb;
  logic               clk = 1'b0, rstn = 1'b0, in_valid = 1'b0, stall = 1'b1;
  mhf_pkg::mhf_beat_t in_beat = '0;
  mhf_pkg::mhf_meta_t in_meta = '0;
  logic [31:0]        fill_to = 32'hFFFF_FFFF;
  logic               time_set = 1'b0, off_valid = 1'b0, ntp_sync = 1'b0, time_ok = 1'b0;
  logic [63:0]        time_val = 64'h0000_0007_0000_0000, time_now, t_prev = '0;
  logic [4:0]         stat = '0;
  logic               lk1 = 1'b0, lk10 = 1'b0, in_ready, out_valid, out_ready, out_last;
  logic [63:0]        out_data;
  mhf_pkg::mhf_cnt_t  cnt;
  logic               ev_loss, ev_ntp, ev_l1, ev_l10, seen, obs_done;
  int                 error_cnt = 0, checks_done = 0, loss_n = 0, l1_n = 0, l10_n = 0;

  mhf_framer #(.OBS_CYCLES(40'd100)) dut (
    .sys_clk_i(clk), .rstn_i(rstn), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .in_beat_i(in_beat), .in_meta_i(in_meta), .out_valid_o(out_valid),
    .out_ready_i(out_ready), .out_data_o(out_data), .out_last_o(out_last),
    .fill_timeout_i(fill_to), .time_set_i(time_set), .time_set_val_i(time_val),
    .ntp_off_valid_i(off_valid), .ntp_off_i(-32'sd40), .ntp_sync_i(ntp_sync),
    .time_o(time_now), .rx_frame_i(stat[0]), .crc_err_i(stat[1]), .match_i(stat[2]),
    .proc_drop_i(stat[3]), .queue_drop_i(stat[4]), .cnt_o(cnt), .link1g_i(lk1),
    .link10g_i(lk10), .ev_loss_o(ev_loss), .ev_ntp_sync_o(ev_ntp), .ev_link1g_o(ev_l1),
    .ev_link10g_o(ev_l10), .traffic_seen_o(seen), .obs_done_o(obs_done));
  mhf_sink_model sink (.sys_clk_i(clk), .rstn_i(rstn), .out_valid_i(out_valid),
    .out_ready_o(out_ready), .out_data_i(out_data), .out_last_i(out_last), .stall_i(stall));

  // clock at 200 MHz
  always #2.5 clk = ~clk;
  // tally of event pulses, sampled mid-cycle where they are settled
  always @(negedge clk) begin
    loss_n += int'(ev_loss === 1'b1);
    l1_n += int'(ev_l1 === 1'b1);
    l10_n += int'(ev_l10 === 1'b1);
  end
  // time never steps once it has been set
  always @(negedge clk) begin
    if (time_ok) chk(time_now - t_prev <= 64'd1, "time step");
    t_prev = time_now;
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic send_frame(input mhf_pkg::mhf_meta_t m, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(negedge clk);
      while (in_ready !== 1'b1) @(negedge clk);
      in_valid = 1'b1;
      in_meta = m;
      in_beat.last = (i == nb - 1);
      for (int b = 0; b < 8; b++) in_beat.data[8*b +: 8] = 8'(8 * i + b + 1);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask : send_frame

  task automatic wait_beats(input int n);
    int t;
    t = 0;
    while (sink.beats.size() < n && t < 5000) begin
      @(negedge clk);
      t++;
    end
    chk(sink.beats.size() >= n, "beats missing");
  endtask : wait_beats

  task automatic check_pkt(input logic [7:0] typ, input logic [7:0] src, input logic [23:0] tag,
                           input logic [31:0] seq, input logic [15:0] car, input logic [15:0] orig);
    logic [64:0] h[4];
    logic [64:0] x;
    logic [63:0] e;
    logic [31:0] sum;
    int          nd;
    nd = (int'(car) + 7) / 8;
    sum = '0;
    wait_beats(4 + nd);
    for (int i = 0; i < 4; i++) h[i] = sink.beats.pop_front();
    chk(h[0][63:0] === {src, 16'h0000, typ, 32'h0717_2738}, "hdr beat0");
    chk(h[1][63:0] === {src, tag, seq}, "hdr beat1");
    chk(h[2][63:32] === 32'h7 && h[2][31:0] < 32'h1000, "hdr time");
    chk(h[3][63:32] === {orig, car}, "hdr lengths");
    chk({h[0][64], h[1][64], h[2][64], h[3][64]} === {3'b000, nd == 0}, "hdr last");
    for (int i = 0; i < 4; i++)
      for (int b = 0; b < 8; b++) if (i != 3 || b > 3) sum += 32'(h[i][8*b +: 8]);
    for (int i = 0; i < nd; i++) begin
      x = sink.beats.pop_front();
      for (int b = 0; b < 8; b++) e[8*b +: 8] = (8 * i + b < car) ? 8'(8 * i + b + 1) : 8'h00;
      for (int b = 0; b < 8; b++) sum += 32'(e[8*b +: 8]);
      chk(x === {i == nd - 1, e}, "data beat");
    end
    chk(h[3][31:0] === sum, "checksum");
  endtask : check_pkt

  // two frames back to back against a stalled sink, the second truncated
  task automatic t_frames();
    send_frame('{8'h3C, 24'h12_3456, 16'd20, 16'd0, 1'b0}, 3);
    send_frame('{8'h5A, 24'h00_00C3, 16'd40, 16'd13, 1'b1}, 5);
    repeat (20) @(negedge clk);
    chk(sink.beats.size() == 0 && in_ready === 1'b0, "stall held");
    stall = 1'b0;
    check_pkt(8'h01, 8'h3C, 24'h12_3456, 32'd0, 16'd20, 16'd20);
    check_pkt(8'h01, 8'h5A, 24'h00_00C3, 32'd1, 16'd16, 16'd40);
  endtask : t_frames

  // counters, loss event, traffic interval, sync and link events
  task automatic t_stats();
    int t;
    // start right after an interval end so every pulse falls in one interval
    t = 0;
    while (obs_done !== 1'b1 && t < 300) begin
      @(negedge clk);
      t++;
    end
    chk(t < 300, "interval end missing");
    for (int k = 0; k < 5; k++) repeat (k + 1) begin
      @(negedge clk);
      stat = 5'b00001 << k;
    end
    @(negedge clk);
    stat = '0;
    lk1 = 1'b1;
    lk10 = 1'b1;
    ntp_sync = 1'b1;
    off_valid = 1'b1;
    @(negedge clk);
    off_valid = 1'b0;
    repeat (8) @(negedge clk);
    chk(cnt === {32'd1, 32'd2, 32'd3, 32'd4, 32'd5}, "counters");
    chk(loss_n == 9 && l1_n == 1 && l10_n == 1 && ev_ntp === 1'b1, "events");
    for (int n = 0; n < 2; n++) begin
      t = 0;
      while (obs_done !== 1'b1 && t < 300) begin
        @(negedge clk);
        t++;
      end
      chk(t < 300, "interval end late");
      @(negedge clk);
      chk(seen === (n == 0), "traffic flag");
    end
  endtask : t_stats

  // idle output fills up with fill-in packets to the burst size, then stops
  task automatic t_fill();
    fill_to = 32'd20;
    time_set = 1'b1;
    time_val = 64'h0000_0009_0000_0000;
    @(negedge clk);
    time_set = 1'b0;
    wait_beats(124);
    repeat (300) @(negedge clk);
    chk(sink.beats.size() == 124, "fill count");
    repeat (31) check_pkt(8'h00, 8'h00, 24'h0, 32'd2, 16'd0, 16'd0);
  endtask : t_fill

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    time_set = 1'b1;
    @(negedge clk);
    time_set = 1'b0;
    repeat (2) @(negedge clk);
    time_ok = 1'b1;
    t_frames();
    t_stats();
    t_fill();
    final_report();
  end
  // watchdog
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule : mhf_framer_tb

// File: tb/mhf_sink_model.sv
// sink model of the monitoring pc: accepts the framer's output stream
// assumes the framer's valid/ready output on the same clock
`timescale 1ns/1ps
module mhf_sink_model (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // stream from the framer
  input  wire logic        out_valid_i,
  output logic             out_ready_o,
  input  wire logic [63:0] out_data_i,
  input  wire logic        out_last_i,
  // test control: hold off the stream
  input  wire logic        stall_i
);
  logic [64:0] beats[$];
  // ready is registered: it follows stall_i after a clock edge and clears at once on reset
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) out_ready_o <= 1'b0;
    else out_ready_o <= !stall_i;
  end
  // keep each beat whole; the bench pops beats in order and checks header, data and zero padding
  always @(posedge sys_clk_i) begin
    if (rstn_i && out_valid_i && out_ready_o) beats.push_back({out_last_i, out_data_i});
  end
endmodule : mhf_sink_model
